// ### core/smc_cfg.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_OFS_CTRL     32'h0000_0000
`define SMC_OFS_ACMP     32'h0000_0004
`define SMC_OFS_STAT     32'h0000_0008
`define SMC_ARM_BIT      0
`define SMC_MODE_LSB     1
`define SMC_MODE_MSB     3
`define SMC_ACMP_OFF_BIT 0
`define SMC_CTRL_RST     4'h0
`define SMC_ACMP_RST     1'b0
`define SMC_HALT_CYC     16'h0004
`define SMC_STBY_CYC     16'h0006
`define SMC_UNIT_DEF     1024
`endif

// ### core/smc_pkg.sv
// Types shared by the sleep mode controller files.
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_ACTIVE = 2'b00,
    SMC_SLEEP  = 2'b01,
    SMC_WAKE   = 2'b11,
    SMC_HALT   = 2'b10
  } smc_state_t;
  typedef enum logic [2:0] {
    SMC_M_IDLE  = 3'b000,
    SMC_M_PDOWN = 3'b010,
    SMC_M_PSAVE = 3'b011,
    SMC_M_STBY  = 3'b110,
    SMC_M_XSTBY = 3'b111
  } smc_mode_t;
  typedef struct packed {
    logic [3:0]  ext_irq_lower_lines;
    logic [3:0]  ext_irq_upper_lines;
    logic [3:0]  ext_upper_level_sense;
    logic [12:0] pin_change_irqs;
    logic        twi_addr_match;
    logic        wdt_irq;
    logic        usb_bus_wake_irq;
    logic        usb_frame_start_irq;
    logic        usb_sync_irq;
    logic        mem_ready_irq;
    logic        comparator_irq;
    logic        other_io_irq;
  } smc_wake_t;
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic osc;
  } smc_clk_en_t;
endpackage

// ### core/smc_sync.sv
// Two-flop synchroniser for pin-level inputs, one per bit.
`timescale 1ns/100ps
module smc_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  genvar i;
  // The first stage feeds only the second stage of the same bit.
  for (i = 0; i < W; i++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else begin
        meta_reg <= din[i];
        sync_reg <= meta_reg;
      end
    end
    assign dout[i] = sync_reg;
  end
endmodule

// ### core/smc_wake_qual.sv
// Selects which wake sources may end the current sleep mode.
`timescale 1ns/100ps
module smc_wake_qual
  import smc_pkg::*;
(
  input  wire logic      idle_mode,
  input  wire logic      comparator_off,
  input  wire smc_wake_t src,
  output logic           wake_hit
);
  logic any_idle;
  logic any_deep;
  // Idle lets every enabled source wake; deep modes only the async set.
  always_comb begin
    any_idle = (|src.ext_irq_lower_lines) | (|src.ext_irq_upper_lines)
             | (|src.pin_change_irqs) | src.twi_addr_match | src.wdt_irq
             | src.usb_bus_wake_irq | src.usb_frame_start_irq
             | src.usb_sync_irq | src.mem_ready_irq | src.other_io_irq
             | (src.comparator_irq & ~comparator_off);
    // Upper external lines count only when set for level sense.
    any_deep = (|src.ext_irq_lower_lines)
             | (|(src.ext_irq_upper_lines & src.ext_upper_level_sense))
             | (|src.pin_change_irqs) | src.twi_addr_match | src.wdt_irq
             | src.usb_bus_wake_irq;
    wake_hit = idle_mode ? any_idle : any_deep;
  end
endmodule

// ### core/smc_top.sv
// Sleep mode sequencer with its AHB-Lite register slave.
`timescale 1ns/100ps
`include "smc_cfg.svh"
// Functional notes
// - Sleep is entered only if the arm bit is set when sleep executes.
// - Mode field bits 3..1 picks idle, power-down, power-save or a standby.
// - Interrupt wake holds the core four cycles after start-up, then resumes.
// - Register file and SRAM keep their contents through sleep and wake.
// - A reset during sleep wakes the core to the reset vector unless a same-clock source is raised with it.
// - Control register bits 7..4 always read as zero.
// - Idle stops only CPU and flash clocks; I/O clock and oscillator run.
// - In idle any enabled interrupt wakes the core.
// - Comparator-off bit powers down the comparator and drops its wake.
// - Power-down stops the oscillator and every generated clock.
// - Power-down wakes only from async sources, upper lines level only.
// - Power-down wake waits a start-up period set by clock-select fuses.
// - Power-save behaves exactly like power-down.
// - Standby with crystal keeps the oscillator, wakes in six cycles.
// - Extended standby behaves like standby.
// - Deep modes ignore synchronous USB, memory-ready and other I/O.
// - I/O clock only in idle; oscillator in idle and in standby with a crystal.
module smc_top
  import smc_pkg::*;
#(
  parameter int STARTUP_UNIT = `SMC_UNIT_DEF
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        sleep_exec,
  input  wire smc_wake_t   wake_src,
  input  wire logic        sys_reset_req,
  input  wire logic        ext_crystal_sel,
  input  wire logic [3:0]  clock_select_fuses,
  output smc_clk_en_t      clk_en,
  output logic             comparator_pwr,
  output logic             core_halted,
  output logic             core_resume,
  output logic             resume_at_reset,
  output logic      [1:0]  sleep_state
);
  // Pin-side inputs pass two flops before any logic reads them.
  localparam int SW = 27;
  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  smc_wake_t     wake_s;
  logic          rst_req_s;
  logic          xtal_s;
  logic [3:0]    fuse_s;
  assign sync_in = {wake_src.ext_irq_lower_lines,
                    wake_src.ext_irq_upper_lines,
                    wake_src.pin_change_irqs,
                    sys_reset_req, ext_crystal_sel, clock_select_fuses};
  smc_sync #(.W(SW)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (sync_in),
    .dout    (sync_out)
  );
  // Internal peripheral requests are on this clock and need no flops.
  always_comb begin
    wake_s = wake_src;
    wake_s.ext_irq_lower_lines = sync_out[26:23];
    wake_s.ext_irq_upper_lines = sync_out[22:19];
    wake_s.pin_change_irqs     = sync_out[18:6];
  end
  assign rst_req_s = sync_out[5];
  assign xtal_s    = sync_out[4];
  assign fuse_s    = sync_out[3:0];

  // AHB-Lite slave state.
  logic [3:0]  ctrl_reg;
  logic [3:0]  ctrl_next;
  logic        acmp_off_reg;
  logic        acmp_off_next;
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [31:0] wr_addr_reg;
  logic [31:0] wr_addr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        ap_valid;

  // Sequencer state.
  smc_state_t  state_reg;
  smc_state_t  state_next;
  logic [2:0]  mode_reg;
  logic [2:0]  mode_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        at_reset_reg;
  logic        at_reset_next;
  logic        resume_reg;
  logic        resume_next;
  smc_clk_en_t clk_reg;
  smc_clk_en_t clk_next;
  logic        wake_hit;
  logic        mode_ok;
  logic        arm;
  logic        keep_osc;
  logic [15:0] startup_load;

  assign arm = ctrl_reg[`SMC_ARM_BIT];

  // Zero-wait slave: every transfer finishes in one data phase, OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign ap_valid  = hsel & hready & htrans[1];

  // Read data is captured at the address phase from current state.
  always_comb begin
    ctrl_next     = ctrl_reg;
    acmp_off_next = acmp_off_reg;
    wr_pend_next  = ap_valid & hwrite;
    wr_addr_next  = ap_valid ? haddr : wr_addr_reg;
    hrdata_next   = hrdata_reg;
    if (ap_valid && !hwrite) begin
      case (haddr)
        `SMC_OFS_CTRL: hrdata_next = {28'h000_0000, ctrl_reg};
        `SMC_OFS_ACMP: hrdata_next = {31'h0000_0000, acmp_off_reg};
        `SMC_OFS_STAT: hrdata_next = {26'h000_0000, state_reg,
                                      mode_reg, at_reset_reg};
        default:       hrdata_next = 32'h0000_0000;
      endcase
    end
    // Unmapped writes are dropped; only the low bits are stored.
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        `SMC_OFS_CTRL: ctrl_next     = hwdata[3:0];
        `SMC_OFS_ACMP: acmp_off_next = hwdata[`SMC_ACMP_OFF_BIT];
        default:       ctrl_next     = ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= `SMC_CTRL_RST;
      acmp_off_reg <= `SMC_ACMP_RST;
      wr_pend_reg  <= 1'b0;
      wr_addr_reg  <= 32'h0000_0000;
      hrdata_reg   <= 32'h0000_0000;
    end else begin
      ctrl_reg     <= ctrl_next;
      acmp_off_reg <= acmp_off_next;
      wr_pend_reg  <= wr_pend_next;
      wr_addr_reg  <= wr_addr_next;
      hrdata_reg   <= hrdata_next;
    end
  end

  smc_wake_qual u_qual (
    .idle_mode      (mode_reg == SMC_M_IDLE),
    .comparator_off (acmp_off_reg),
    .src            (wake_s),
    .wake_hit       (wake_hit)
  );

  // Reserved codes are refused like an unarmed sleep.
  always_comb begin
    case (ctrl_reg[`SMC_MODE_MSB:`SMC_MODE_LSB])
      SMC_M_IDLE, SMC_M_PDOWN, SMC_M_PSAVE,
      SMC_M_STBY, SMC_M_XSTBY: mode_ok = 1'b1;
      default:                 mode_ok = 1'b0;
    endcase
  end

  // Standby needs a crystal; without it the mode falls back to power-down.
  assign keep_osc = mode_reg[2] & mode_reg[1] & xtal_s;
  // Start-up wait scales with the fuses; the unit is a parameter.
  assign startup_load = 16'(STARTUP_UNIT * (int'(fuse_s) + 1) - 1);

  // Sequencer: arm, sleep, restart the clock, halt, then resume.
  always_comb begin
    state_next    = state_reg;
    mode_next     = mode_reg;
    cnt_next      = cnt_reg;
    at_reset_next = at_reset_reg;
    resume_next   = 1'b0;
    case (state_reg)
      SMC_ACTIVE: begin
        if (sleep_exec && arm && mode_ok) begin
          state_next    = SMC_SLEEP;
          mode_next     = ctrl_reg[`SMC_MODE_MSB:`SMC_MODE_LSB];
          at_reset_next = 1'b0;
        end
      end
      SMC_SLEEP: begin
        if (rst_req_s || wake_hit) begin
          state_next    = SMC_WAKE;
          at_reset_next = rst_req_s;
          if (keep_osc || mode_reg == SMC_M_IDLE) begin
            cnt_next = `SMC_STBY_CYC - 16'h0001;
          end else begin
            cnt_next = startup_load;
          end
        end
      end
      SMC_WAKE: begin
        if (cnt_reg == 16'h0000) begin
          state_next = SMC_HALT;
          cnt_next   = `SMC_HALT_CYC - 16'h0001;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      SMC_HALT: begin
        if (cnt_reg == 16'h0000) begin
          state_next  = SMC_ACTIVE;
          resume_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: state_next = SMC_ACTIVE;
    endcase
  end

  // Clock gates follow the next state so they switch with it.
  always_comb begin
    clk_next = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
    case (state_next)
      SMC_SLEEP: begin
        clk_next.cpu   = 1'b0;
        clk_next.flash = 1'b0;
        clk_next.io    = (mode_next == SMC_M_IDLE);
        clk_next.osc   = (mode_next == SMC_M_IDLE)
                       | (mode_next[2] & mode_next[1] & xtal_s);
      end
      SMC_WAKE: begin
        clk_next.cpu   = 1'b0;
        clk_next.flash = 1'b0;
        clk_next.io    = 1'b0;
      end
      SMC_HALT: begin
        clk_next.cpu   = 1'b0;
      end
      default: clk_next = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
    endcase
  end

  // Reset only restarts the sequencer; memories are never touched here.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= SMC_ACTIVE;
      mode_reg     <= 3'h0;
      cnt_reg      <= 16'h0000;
      at_reset_reg <= 1'b0;
      resume_reg   <= 1'b0;
      clk_reg      <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      cnt_reg      <= cnt_next;
      at_reset_reg <= at_reset_next;
      resume_reg   <= resume_next;
      clk_reg      <= clk_next;
    end
  end

  assign clk_en          = clk_reg;
  assign comparator_pwr  = ~acmp_off_reg;
  assign core_halted     = (state_reg != SMC_ACTIVE);
  assign core_resume     = resume_reg;
  assign resume_at_reset = at_reset_reg;
  assign sleep_state     = state_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_enter_halt;
    state_reg == SMC_WAKE ##1 state_reg == SMC_HALT;
  endsequence
  sequence s_stby_wake;
    state_reg == SMC_SLEEP && wake_hit && !rst_req_s && keep_osc;
  endsequence

  property p_unarmed_nop;
    state_reg == SMC_ACTIVE && sleep_exec && !arm
      |=> state_reg == SMC_ACTIVE && clk_en.cpu;
  endproperty
  a_unarmed_nop: assert property (p_unarmed_nop)
    else $error("Unarmed sleep left the active state.");

  property p_arm_mode;
    state_reg == SMC_ACTIVE && sleep_exec && arm && mode_ok
      |=> state_reg == SMC_SLEEP
          && mode_reg == $past(ctrl_reg[`SMC_MODE_MSB:`SMC_MODE_LSB]);
  endproperty
  a_arm_mode: assert property (p_arm_mode)
    else $error("Armed sleep did not latch the selected mode.");

  property p_idle_clocks;
    state_reg == SMC_SLEEP && mode_reg == SMC_M_IDLE
      |-> !clk_en.cpu && !clk_en.flash && clk_en.io && clk_en.osc;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks)
    else $error("Idle clock gating is wrong.");

  property p_pdown_clocks;
    state_reg == SMC_SLEEP && mode_reg[2:1] == 2'b01
      |-> clk_en == '{cpu: 1'b0, flash: 1'b0, io: 1'b0, osc: 1'b0};
  endproperty
  a_pdown_clocks: assert property (p_pdown_clocks)
    else $error("Power-down left a clock running.");

  property p_stby_clocks;
    state_reg == SMC_SLEEP && keep_osc |-> clk_en.osc && !clk_en.io;
  endproperty
  a_stby_clocks: assert property (p_stby_clocks)
    else $error("Standby oscillator or I/O clock is wrong.");

  property p_halt_four;
    s_enter_halt |-> (state_reg == SMC_HALT)[*4] ##1
                     (state_reg == SMC_ACTIVE && core_resume);
  endproperty
  a_halt_four: assert property (p_halt_four)
    else $error("Halt after wake did not last four cycles.");

  property p_stby_six;
    s_stby_wake |=> (state_reg == SMC_WAKE)[*6] ##1 state_reg == SMC_HALT;
  endproperty
  a_stby_six: assert property (p_stby_six)
    else $error("Standby wake did not take six cycles.");

  property p_reset_vector;
    state_reg == SMC_SLEEP && rst_req_s
      |=> state_reg == SMC_WAKE && resume_at_reset;
  endproperty
  a_reset_vector: assert property (p_reset_vector)
    else $error("Reset in sleep did not select the reset vector.");

  property p_deep_ignore;
    state_reg == SMC_SLEEP && mode_reg != SMC_M_IDLE && !rst_req_s
      && wake_s == '{usb_sync_irq: 1'b1, default: 1'b0}
      |=> state_reg == SMC_SLEEP;
  endproperty
  a_deep_ignore: assert property (p_deep_ignore)
    else $error("Synchronous USB event woke a deep sleep mode.");

  property p_ctrl_reserved;
    ap_valid && !hwrite && haddr == `SMC_OFS_CTRL |=> hrdata[31:4] == 0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)
    else $error("Reserved control bits read non-zero.");
endmodule

// ### bench/smc_core_model.sv
// Processor core model that executes the sleep instruction on request.
`timescale 1ns/100ps
module smc_core_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic exec_req,
  input  wire logic core_halted,
  output logic      sleep_exec
);
  // A halted core fetches nothing, so the one-cycle sleep pulse is only
  // issued while the core runs; software has written the arm bit first.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_exec <= 1'b0;
    end else begin
      sleep_exec <= exec_req & ~core_halted;
    end
  end
endmodule

// ### bench/test_sleep_mode_controller.sv
// Self-checking bench for the sleep mode sequencer and its registers.
`timescale 1ns/100ps
module test_sleep_mode_controller;
  import smc_pkg::*;
  // A short start-up unit keeps the deep-mode waits brief; fuses give 4 steps.
  localparam int UNIT = 2;
  localparam int NPD  = UNIT * 4;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire         hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        exec_req;
  logic        sleep_exec;
  smc_wake_t   wake_src;
  logic        sys_reset_req;
  logic        ext_crystal_sel;
  logic [3:0]  fuses;
  smc_clk_en_t clk_en;
  logic        comparator_pwr;
  logic        core_halted;
  logic        core_resume;
  logic        resume_at_reset;
  logic [1:0]  sleep_state;
  int          err_total;
  int          check_count;
  logic [31:0] rd;
  logic [2:0]  mtab [6] = '{3'd0, 3'd2, 3'd3, 3'd6, 3'd7, 3'd6};
  logic        xtab [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [3:0]  ctab [6] = '{4'h3, 4'h0, 4'h0, 4'h1, 4'h1, 4'h0};
  int          ntab [6] = '{6, NPD, NPD, 6, 6, NPD};

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  smc_top #(.STARTUP_UNIT(UNIT)) u_smc_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleep_exec(sleep_exec), .wake_src(wake_src),
    .sys_reset_req(sys_reset_req), .ext_crystal_sel(ext_crystal_sel),
    .clock_select_fuses(fuses), .clk_en(clk_en),
    .comparator_pwr(comparator_pwr), .core_halted(core_halted),
    .core_resume(core_resume), .resume_at_reset(resume_at_reset),
    .sleep_state(sleep_state)
  );

  smc_core_model u_smc_core_model (
    .hclk(hclk), .hresetn(hresetn), .exec_req(exec_req),
    .core_halted(core_halted), .sleep_exec(sleep_exec)
  );

  // Free-running 100 MHz clock.
  always #5 hclk = ~hclk;

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task ahb_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  // Read data is taken at the edge that ends the data phase.
  task rchk(input logic [31:0] a, input logic [31:0] e, input string m);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk(rd, e, m);
    chk(hresp, 1'b0, "okay response");
  endtask

  // Writes the control word, then has the core execute the sleep instruction.
  task enter(input logic [2:0] m, input logic arm);
    ahb_write(32'h0000_0000, {28'h000_0000, m, arm});
    @(posedge hclk);
    exec_req <= 1'b1;
    @(posedge hclk);
    exec_req <= 1'b0;
    repeat (3) @(negedge hclk);
  endtask

  function automatic smc_wake_t ws(input int k);
    smc_wake_t r;
    r = '0;
    case (k)
      0: r.usb_frame_start_irq = 1'b1;
      1: r.comparator_irq = 1'b1;
      2: r.usb_sync_irq = 1'b1;
      3: r.mem_ready_irq = 1'b1;
      4: r.other_io_irq = 1'b1;
      5: r.ext_irq_upper_lines = 4'h8;
      6: r.wdt_irq = 1'b1;
      7: r.twi_addr_match = 1'b1;
      8: r.pin_change_irqs = 13'h1000;
      9: r.ext_irq_lower_lines = 4'h1;
      10: begin
        r.ext_irq_upper_lines = 4'h2;
        r.ext_upper_level_sense = 4'h2;
      end
      default: r.usb_bus_wake_irq = 1'b1;
    endcase
    return r;
  endfunction

  // The source holds its level until the core resumes, as a level wake needs.
  task wake(input smc_wake_t s, input int n, input logic rst);
    int          w;
    int          h;
    int          t;
    logic [3:0]  hc;
    w = 0;
    h = 0;
    t = 0;
    hc = 4'hx;
    @(posedge hclk);
    wake_src <= s;
    sys_reset_req <= rst;
    while (core_resume !== 1'b1 && t < 2000) begin
      @(negedge hclk);
      t++;
      if (sleep_state === 2'b11) w++;
      if (sleep_state === 2'b10) begin
        h++;
        hc = clk_en;
      end
    end
    chk(w, n, "start-up wait");
    chk(h, 4, "halt cycles");
    chk(hc, 4'h7, "halt clocks");
    chk(clk_en, 4'hF, "resumed clocks");
    chk(resume_at_reset, rst, "resume point");
    @(posedge hclk);
    wake_src <= '0;
    sys_reset_req <= 1'b0;
  endtask

  task no_wake(input smc_wake_t s);
    @(posedge hclk);
    wake_src <= s;
    repeat (10) @(negedge hclk);
    chk(sleep_state, 2'b01, "ignored source");
    @(posedge hclk);
    wake_src <= '0;
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the full sequence needs well under 5000 cycles.
  initial begin
    repeat (30000) @(posedge hclk);
    err_total++;
    complete_run();
  end

  // Main sequence: reset, registers, refused sleeps, every mode and source.
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    exec_req = 1'b0;
    wake_src = '0;
    sys_reset_req = 1'b0;
    ext_crystal_sel = 1'b1;
    fuses = 4'h3;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk(32'h0000_0000, 32'h0000_0000, "ctrl reset");
    rchk(32'h0000_0004, 32'h0000_0000, "comparator reset");
    rchk(32'h0000_000C, 32'h0000_0000, "unmapped read");
    chk(clk_en, 4'hF, "reset clocks");
    ahb_write(32'h0000_0000, 32'hFFFF_FFFF);
    rchk(32'h0000_0000, 32'h0000_000F, "reserved bits");
    $display("test registers done");
    enter(3'd2, 1'b0);
    chk(sleep_state, 2'b00, "unarmed sleep");
    chk(clk_en, 4'hF, "unarmed clocks");
    for (int i = 0; i < 3; i++) begin
      enter(i == 0 ? 3'd1 : 3'(i + 3), 1'b1);
      chk(sleep_state, 2'b00, "reserved mode");
    end
    $display("test refused sleep done");
    for (int i = 0; i < 6; i++) begin
      @(posedge hclk);
      ext_crystal_sel <= xtab[i];
      enter(mtab[i], 1'b1);
      chk(sleep_state, 2'b01, "armed sleep");
      chk(core_halted, 1'b1, "core halted");
      chk(clk_en, ctab[i], "mode clocks");
      wake(ws(6), ntab[i], 1'b0);
      rchk(32'h0000_0000, {28'h000_0000, mtab[i], 1'b1}, "kept");
      ahb_write(32'h0000_0000, 32'h0000_0000);
    end
    $display("test modes done");
    ext_crystal_sel <= 1'b1;
    enter(3'd2, 1'b1);
    for (int k = 0; k < 6; k++) no_wake(ws(k));
    // Reset alone: a same-clock source would win the race through the
    // reset synchroniser and resume after the sleep instruction instead.
    wake('0, NPD, 1'b1);
    rchk(32'h0000_0008, 32'h0000_0005, "status");
    for (int k = 7; k < 12; k++) begin
      enter(3'd2, 1'b1);
      wake(ws(k), NPD, 1'b0);
    end
    // One fuse step gives one unit of start-up wait.
    fuses <= 4'h0;
    enter(3'd2, 1'b1);
    wake(ws(6), UNIT, 1'b0);
    fuses <= 4'h3;
    $display("test deep sources done");
    for (int k = 0; k < 12; k++) begin
      enter(3'd0, 1'b1);
      wake(ws(k), 6, 1'b0);
    end
    ahb_write(32'h0000_0004, 32'h0000_0001);
    rchk(32'h0000_0004, 32'h0000_0001, "comparator off");
    chk(comparator_pwr, 1'b0, "comparator power");
    enter(3'd0, 1'b1);
    no_wake(ws(1));
    wake(ws(4), 6, 1'b0);
    ahb_write(32'h0000_0004, 32'h0000_0000);
    @(negedge hclk);
    chk(comparator_pwr, 1'b1, "comparator on");
    $display("test idle sources done");
    complete_run();
  end
endmodule
